// File: include/drgc_defines.svh
// register offsets, field positions, reset values and counts of the gain block
`ifndef DRGC_DEFINES_SVH
`define DRGC_DEFINES_SVH

`define DRGC_OFF_CTRL      8'h00
`define DRGC_OFF_VOL       8'h04
`define DRGC_OFF_COMPTH    8'h08
`define DRGC_OFF_LIMTH     8'h0C
`define DRGC_OFF_EXPTH     8'h10
`define DRGC_OFF_RATIO     8'h14
`define DRGC_OFF_TIME      8'h18
`define DRGC_OFF_MUGAIN    8'h1C
`define DRGC_OFF_CADDR     8'h20
`define DRGC_OFF_CWR_LO    8'h24
`define DRGC_OFF_CWR_MID   8'h28
`define DRGC_OFF_CWR_HI    8'h2C
`define DRGC_OFF_CREAD     8'h30
`define DRGC_OFF_STATUS    8'h34

`define DRGC_CTRL_COMP     0
`define DRGC_CTRL_LIMIT    1
`define DRGC_CTRL_EXP      2
`define DRGC_CTRL_WINSEL   3
`define DRGC_CTRL_PEAK     4

`define DRGC_RST_CTRL      5'h00
`define DRGC_RST_VOL       8'hFF
`define DRGC_RST_COMPTH    8'h00
`define DRGC_RST_LIMTH     8'hFF
`define DRGC_RST_EXPTH     8'h00
`define DRGC_RST_CRATIO    5'h01
`define DRGC_RST_ERATIO    3'h1
`define DRGC_RST_ATTACK    8'h00
`define DRGC_RST_RELEASE   8'h00
`define DRGC_RST_MUGAIN    5'h00

`define DRGC_CRAM_WORDS    176
`define DRGC_CRAM_LAST     8'hAF
`define DRGC_BASS_BASE     8'h80
`define DRGC_TREB_BASE     8'h97
`define DRGC_WIDEN_COEF    8'hAE
`define DRGC_WIDEN_MIX     8'hAF
`define DRGC_B0_EXT1       8'h00
`define DRGC_B0_EXT2       8'h05
`define DRGC_B0_LMT        8'h0C
`define DRGC_B0_CTO        8'h11
`define DRGC_NLF_M1        8'h0A
`define DRGC_NLF_M2        8'h0B
`define DRGC_UNITY_Q22     24'h400000
`define DRGC_UNITY_Q20     24'h100000
`define DRGC_FRAC_Q22      22

`define DRGC_POS_FS        24'h7FFFFF
`define DRGC_NEG_FS        24'h800000
`define DRGC_WIN_LONG_MAX  9'h1FF
`define DRGC_WIN_SHORT_MAX 9'h03F
`define DRGC_WIN_LONG_SH   9
`define DRGC_WIN_SHORT_SH  6

`endif

// File: include/drgc_pkg.sv
// types shared by the gain and dynamic range block
package drgc_pkg;

   typedef enum logic [2:0] {
      CR_INIT,
      CR_IDLE,
      CR_WRITE,
      CR_FETCH,
      CR_LATCH
   } drgc_cram_state_t;

   typedef logic signed [23:0] drgc_sample_t;
   typedef logic        [7:0]  drgc_steps_t;

endpackage

// File: rtl/drgc_coef_ram.sv
// single-port synchronous coefficient store, one 24-bit word per address
`timescale 1ns/10ps
`include "drgc_defines.svh"

module drgc_coef_ram
   import drgc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        ramWe,
   input  wire logic [7:0]  ramAddr,
   input  wire logic [23:0] ramWdata,
   output logic      [23:0] ramQ
);

   logic [23:0] mem [`DRGC_CRAM_WORDS];
   logic        inRange;

   assign inRange = ramAddr <= `DRGC_CRAM_LAST;

   // contents are not reset here; the owner walks every word after reset
   always_ff @(posedge core_clk) begin
      if (ramWe && inRange) begin
         mem[ramAddr] <= ramWdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ramQ <= 24'h000000;
      end else begin
         ramQ <= inRange ? mem[ramAddr] : 24'h000000;
      end
   end

endmodule

// File: rtl/drgc_top.sv
// gain and dynamic range control: volume, compressor, limiter, expander
//
// Operation
// - bass from 0x80, treble from 0x97, widening coef and mix at 0xAE/0xAF
// - after reset B0 words hold unity, every other word holds zero
// - nonlinear factors are signed Q3.20, range +/-8, unity 100000h
// - other coefficients are signed Q1.22, range +/-2
// - each channel volume spans -95.625 dB to 0 dB in 0.375 dB steps
// - volume product saturates at 24-bit limits instead of wrapping
// - last step clamps every output sample to full scale
// - limiting, compression and expansion act beside plain volume
// - limiter has its own threshold, apart from the compressor's
// - above compressor threshold gain drops according to ratio
// - below expander threshold gain drops further
// - compressed output range equals input range divided by ratio
// - attack smooths rising attenuation, release smooths falling one
// - makeup gain lifts the compressed level
// - coefficients live in a single-port synchronous store, reached indirectly
// - address, low, middle, high byte; high byte starts write, busy until done
`timescale 1ns/10ps
`include "drgc_defines.svh"

module drgc_top
   import drgc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        inValid,
   input  wire logic [23:0] inLeft,
   input  wire logic [23:0] inRight,
   output logic             inReady,
   output logic             outValid,
   input  wire logic        outReady,
   output logic      [23:0] outLeft,
   output logic      [23:0] outRight
);

   // gain of 2^(-k/16) in Q1.22; one step is 0.375 dB, sixteen make 6 dB
   function automatic logic [23:0] octMant(input logic [3:0] k);
      case (k)
         4'h1:    octMant = 24'h3D4961;
         4'h2:    octMant = 24'h3AB035;
         4'h3:    octMant = 24'h38333C;
         4'h4:    octMant = 24'h35D13F;
         4'h5:    octMant = 24'h338921;
         4'h6:    octMant = 24'h3159C9;
         4'h7:    octMant = 24'h2F4225;
         4'h8:    octMant = 24'h2D413D;
         4'h9:    octMant = 24'h2B5613;
         4'hA:    octMant = 24'h297FB9;
         4'hB:    octMant = 24'h27BD4F;
         4'hC:    octMant = 24'h260DFC;
         4'hD:    octMant = 24'h2470F5;
         4'hE:    octMant = 24'h22E572;
         4'hF:    octMant = 24'h216AAC;
         default: octMant = `DRGC_UNITY_Q22;
      endcase
   endfunction

   // attenuate by a count of 0.375 dB steps
   function automatic logic signed [39:0] scaleDown(input drgc_sample_t x,
                                                    input drgc_steps_t st);
      logic signed [48:0] prod;
      prod = x * $signed({1'b0, octMant(st[3:0])});
      prod = prod >>> (`DRGC_FRAC_Q22 + st[7:4]);
      scaleDown = prod[39:0];
   endfunction

   function automatic drgc_sample_t sat24(input logic signed [39:0] v);
      if (v[39:23] != {17{v[39]}}) begin
         sat24 = v[39] ? `DRGC_NEG_FS : `DRGC_POS_FS;
      end else begin
         sat24 = v[23:0];
      end
   endfunction

   // level below full scale in 0.375 dB steps, log2 taken piecewise linear
   function automatic drgc_steps_t levelSteps(input logic [23:0] mag);
      logic [4:0]  lead;
      logic [23:0] norm;
      logic [9:0]  acc;
      lead = 5'h00;
      for (int i = 0; i < 24; i++) begin
         if (mag[i]) begin
            lead = 5'(i);
         end
      end
      norm = mag << (5'd23 - lead);
      acc  = {1'b0, 5'd23 - lead, 4'h0} - {6'h00, norm[22:19]};
      if (mag == 24'h000000 || acc > 10'h0FF) begin
         levelSteps = 8'hFF;
      end else begin
         levelSteps = acc[7:0];
      end
   endfunction

   // power-on contents of the coefficient store
   function automatic logic [23:0] coefDefault(input logic [7:0] a);
      logic [7:0] off;
      logic       inTone;
      inTone = 1'b1;
      off    = 8'h00;
      if (a >= `DRGC_BASS_BASE && a < `DRGC_TREB_BASE) begin
         off = a - `DRGC_BASS_BASE;
      end else if (a >= `DRGC_TREB_BASE && a < `DRGC_WIDEN_COEF) begin
         off = a - `DRGC_TREB_BASE;
      end else begin
         inTone = 1'b0;
      end
      if (inTone && (off == `DRGC_B0_EXT1 || off == `DRGC_B0_EXT2 ||
                     off == `DRGC_B0_LMT || off == `DRGC_B0_CTO)) begin
         coefDefault = `DRGC_UNITY_Q22;
      end else begin
         coefDefault = 24'h000000;
      end
   endfunction

   // bus and register state
   logic              ack_r;
   logic [31:0]       dat_r;
   logic [31:0]       rdMux;
   logic [4:0]        ctrl_r;
   logic [7:0]        vol_r [2];
   logic [7:0]        compTh_r;
   logic [7:0]        limTh_r;
   logic [7:0]        expTh_r;
   logic [4:0]        compRatio_r;
   logic [2:0]        expRatio_r;
   logic [7:0]        attack_r;
   logic [7:0]        release_r;
   logic [4:0]        mug_r;
   logic              wbReq;
   logic              wbWr;
   logic              wbRd;

   // coefficient store access
   drgc_cram_state_t  cramState_r;
   drgc_cram_state_t  cramState_nxt;
   logic [7:0]        initAddr_r;
   logic [7:0]        cramAddr_r;
   logic [7:0]        wrLo_r;
   logic [7:0]        wrMid_r;
   logic [7:0]        wrHi_r;
   logic [23:0]       readData_r;
   logic              cramIdle;
   logic              addrWr;
   logic              hiWr;
   logic              readPop;
   logic              coefWriteBusy;
   logic              nlfAddr;
   logic              ramWe;
   logic [7:0]        ramAddr;
   logic [23:0]       ramWdata;
   logic [23:0]       ramQ;

   // level detector and gain computer
   logic [8:0]        winCnt_r;
   logic [23:0]       peak_r;
   logic [32:0]       sum_r;
   logic [23:0]       magL;
   logic [23:0]       magR;
   logic [23:0]       mag;
   logic              winLast;
   logic [23:0]       blockMag;
   drgc_steps_t       lvl;
   drgc_steps_t       lastLevel_r;
   drgc_steps_t       compOver;
   drgc_steps_t       compAtt;
   drgc_steps_t       limOver;
   drgc_steps_t       expUnder;
   drgc_steps_t       dynAtt;
   drgc_steps_t       target;
   logic [4:0]        compDiv;
   logic [2:0]        expMul;
   logic [10:0]       expAtt;
   logic [10:0]       totAtt;
   logic [15:0]       gainAtt_r;
   logic [15:0]       targetFx;
   logic [7:0]        coeff;
   logic [25:0]       mix;
   logic [3:0]        mugShift;
   logic [5:0]        mugDiff;
   drgc_steps_t       mugSteps;
   drgc_sample_t      chIn [2];
   drgc_sample_t      chOut [2];

   // two-entry output buffer
   logic              accept;
   logic              pop;
   logic [1:0]        count_r;
   logic [1:0]        count_nxt;
   logic [47:0]       ent0_r;
   logic [47:0]       ent1_r;
   logic              outValid_r;
   logic              inReady_r;

   assign wbReq = cyc_i & stb_i & ~ack_r;
   assign wbWr  = wbReq & we_i;
   assign wbRd  = wbReq & ~we_i;

   // one wait state: ack a cycle after the request, dropped the cycle after
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wbReq;
      end
   end

   always_comb begin
      case (adr_i)
         `DRGC_OFF_CTRL:   rdMux = {27'h0000000, ctrl_r};
         `DRGC_OFF_VOL:    rdMux = {16'h0000, vol_r[1], vol_r[0]};
         `DRGC_OFF_COMPTH: rdMux = {24'h000000, compTh_r};
         `DRGC_OFF_LIMTH:  rdMux = {24'h000000, limTh_r};
         `DRGC_OFF_EXPTH:  rdMux = {24'h000000, expTh_r};
         `DRGC_OFF_RATIO:  rdMux = {21'h000000, expRatio_r, 3'h0,
                                    compRatio_r};
         `DRGC_OFF_TIME:   rdMux = {16'h0000, release_r, attack_r};
         `DRGC_OFF_MUGAIN: rdMux = {27'h0000000, mug_r};
         `DRGC_OFF_CADDR:  rdMux = {24'h000000, cramAddr_r};
         `DRGC_OFF_CWR_LO: rdMux = {24'h000000, wrLo_r};
         `DRGC_OFF_CWR_MID: rdMux = {24'h000000, wrMid_r};
         `DRGC_OFF_CWR_HI: rdMux = {24'h000000, wrHi_r};
         `DRGC_OFF_CREAD:  rdMux = {8'h00, readData_r};
         `DRGC_OFF_STATUS: rdMux = {8'h00, lastLevel_r, gainAtt_r[15:8],
                                    6'h00, nlfAddr, coefWriteBusy};
         default:          rdMux = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         dat_r <= 32'h00000000;
      end else if (wbRd) begin
         dat_r <= rdMux;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ctrl_r      <= `DRGC_RST_CTRL;
         vol_r[0]    <= `DRGC_RST_VOL;
         vol_r[1]    <= `DRGC_RST_VOL;
         compTh_r    <= `DRGC_RST_COMPTH;
         limTh_r     <= `DRGC_RST_LIMTH;
         expTh_r     <= `DRGC_RST_EXPTH;
         compRatio_r <= `DRGC_RST_CRATIO;
         expRatio_r  <= `DRGC_RST_ERATIO;
         attack_r    <= `DRGC_RST_ATTACK;
         release_r   <= `DRGC_RST_RELEASE;
         mug_r       <= `DRGC_RST_MUGAIN;
      end else if (wbWr) begin
         case (adr_i)
            `DRGC_OFF_CTRL: if (sel_i[0]) ctrl_r <= dat_i[4:0];
            `DRGC_OFF_VOL: begin
               if (sel_i[0]) vol_r[0] <= dat_i[7:0];
               if (sel_i[1]) vol_r[1] <= dat_i[15:8];
            end
            `DRGC_OFF_COMPTH: if (sel_i[0]) compTh_r <= dat_i[7:0];
            `DRGC_OFF_LIMTH: if (sel_i[0]) limTh_r <= dat_i[7:0];
            `DRGC_OFF_EXPTH: if (sel_i[0]) expTh_r <= dat_i[7:0];
            `DRGC_OFF_RATIO: begin
               if (sel_i[0]) compRatio_r <= dat_i[4:0];
               if (sel_i[1]) expRatio_r <= dat_i[10:8];
            end
            `DRGC_OFF_TIME: begin
               if (sel_i[0]) attack_r <= dat_i[7:0];
               if (sel_i[1]) release_r <= dat_i[15:8];
            end
            `DRGC_OFF_MUGAIN: if (sel_i[0]) mug_r <= dat_i[4:0];
            default: ;
         endcase
      end
   end

   // coefficient store: writes while busy are dropped, software polls busy
   assign cramIdle = cramState_r == CR_IDLE;
   assign coefWriteBusy = ~cramIdle;
   assign addrWr  = wbWr & sel_i[0] & (adr_i == `DRGC_OFF_CADDR) & cramIdle;
   assign hiWr    = wbWr & sel_i[0] & (adr_i == `DRGC_OFF_CWR_HI) & cramIdle;
   assign readPop = wbRd & (adr_i == `DRGC_OFF_CREAD) & cramIdle;
   // the two nonlinear-factor words of each tone filter, four in all, use Q3.20, the rest Q1.22
   assign nlfAddr = cramAddr_r == `DRGC_BASS_BASE + `DRGC_NLF_M1 ||
                    cramAddr_r == `DRGC_BASS_BASE + `DRGC_NLF_M2 ||
                    cramAddr_r == `DRGC_TREB_BASE + `DRGC_NLF_M1 ||
                    cramAddr_r == `DRGC_TREB_BASE + `DRGC_NLF_M2;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wrLo_r  <= 8'h00;
         wrMid_r <= 8'h00;
         wrHi_r  <= 8'h00;
      end else if (wbWr && sel_i[0] && cramIdle) begin
         if (adr_i == `DRGC_OFF_CWR_LO) wrLo_r <= dat_i[7:0];
         if (adr_i == `DRGC_OFF_CWR_MID) wrMid_r <= dat_i[7:0];
         if (adr_i == `DRGC_OFF_CWR_HI) wrHi_r <= dat_i[7:0];
      end
   end

   always_comb begin
      case (cramState_r)
         CR_INIT:  cramState_nxt = (initAddr_r == `DRGC_CRAM_LAST) ?
                                   CR_FETCH : CR_INIT;
         CR_IDLE:  cramState_nxt = hiWr ? CR_WRITE :
                                   (addrWr | readPop) ? CR_FETCH : CR_IDLE;
         CR_WRITE: cramState_nxt = CR_FETCH;
         CR_FETCH: cramState_nxt = CR_LATCH;
         CR_LATCH: cramState_nxt = CR_IDLE;
         default:  cramState_nxt = CR_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cramState_r <= CR_INIT;
         initAddr_r  <= 8'h00;
      end else begin
         cramState_r <= cramState_nxt;
         if (cramState_r == CR_INIT) begin
            initAddr_r <= initAddr_r + 8'h01;
         end
      end
   end

   // address steps on after each write and each read, for streaming access
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cramAddr_r <= 8'h00;
      end else if (addrWr) begin
         cramAddr_r <= dat_i[7:0];
      end else if (cramState_r == CR_WRITE || readPop) begin
         cramAddr_r <= cramAddr_r + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         readData_r <= 24'h000000;
      end else if (cramState_r == CR_LATCH) begin
         readData_r <= ramQ;
      end
   end

   assign ramWe    = cramState_r == CR_INIT || cramState_r == CR_WRITE;
   assign ramAddr  = (cramState_r == CR_INIT) ? initAddr_r : cramAddr_r;
   assign ramWdata = (cramState_r == CR_INIT) ? coefDefault(initAddr_r) :
                     {wrHi_r, wrMid_r, wrLo_r};

   drgc_coef_ram uCoefRam (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .ramWe    (ramWe),
      .ramAddr  (ramAddr),
      .ramWdata (ramWdata),
      .ramQ     (ramQ)
   );

   // level detection over a block of accepted samples
   assign accept = inValid & inReady_r;
   assign magL = inLeft[23] ? (~inLeft + 24'h000001) : inLeft;
   assign magR = inRight[23] ? (~inRight + 24'h000001) : inRight;
   assign mag  = (magL > magR) ? magL : magR;
   assign winLast = winCnt_r == (ctrl_r[`DRGC_CTRL_WINSEL] ?
                                 `DRGC_WIN_SHORT_MAX : `DRGC_WIN_LONG_MAX);

   always_comb begin
      if (ctrl_r[`DRGC_CTRL_PEAK]) begin
         blockMag = (mag > peak_r) ? mag : peak_r;
      end else if (ctrl_r[`DRGC_CTRL_WINSEL]) begin
         blockMag = 24'((sum_r + 33'(mag)) >> `DRGC_WIN_SHORT_SH);
      end else begin
         blockMag = 24'((sum_r + 33'(mag)) >> `DRGC_WIN_LONG_SH);
      end
   end

   assign lvl = levelSteps(blockMag);

   // thresholds are codes FFh = 0 dB, so ~code is attenuation in steps
   assign compOver = (lvl < ~compTh_r) ? ~compTh_r - lvl : 8'h00;
   assign compDiv  = (compRatio_r == 5'h00) ? 5'h01 : compRatio_r;
   assign compAtt  = compOver - compOver / compDiv;
   assign limOver  = (lvl < ~limTh_r) ? ~limTh_r - lvl : 8'h00;
   assign expUnder = (lvl > ~expTh_r) ? lvl - ~expTh_r : 8'h00;
   assign expMul   = (expRatio_r == 3'h0) ? 3'h0 : expRatio_r - 3'h1;
   assign expAtt   = 11'(expUnder) * 11'(expMul);

   always_comb begin
      dynAtt = 8'h00;
      if (ctrl_r[`DRGC_CTRL_COMP]) begin
         dynAtt = compAtt;
      end
      if (ctrl_r[`DRGC_CTRL_LIMIT] && limOver > dynAtt) begin
         dynAtt = limOver;
      end
      totAtt = 11'(dynAtt);
      if (ctrl_r[`DRGC_CTRL_EXP]) begin
         totAtt = totAtt + expAtt;
      end
      target = (totAtt > 11'h0FF) ? 8'hFF : totAtt[7:0];
   end

   // one-pole smoothing: a larger coefficient means a slower ramp
   assign targetFx = {target, 8'h00};
   assign coeff = (targetFx > gainAtt_r) ? attack_r : release_r;
   assign mix = 26'(coeff) * 26'(gainAtt_r) +
                26'(9'h100 - 9'(coeff)) * 26'(targetFx);

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         winCnt_r    <= 9'h000;
         peak_r      <= 24'h000000;
         sum_r       <= 33'h000000000;
         lastLevel_r <= 8'hFF;
         gainAtt_r   <= 16'h0000;
      end else if (accept) begin
         if (winLast) begin
            winCnt_r    <= 9'h000;
            peak_r      <= 24'h000000;
            sum_r       <= 33'h000000000;
            lastLevel_r <= lvl;
            gainAtt_r   <= mix[23:8];
         end else begin
            winCnt_r <= winCnt_r + 9'h001;
            peak_r   <= (mag > peak_r) ? mag : peak_r;
            sum_r    <= sum_r + 33'(mag);
         end
      end
   end

   // makeup in 1.5 dB steps: shift up whole octaves, trim with the table
   assign mugShift = 4'((6'(mug_r) + 6'h03) >> 2);
   assign mugDiff  = {mugShift, 2'b00} - {1'b0, mug_r};
   assign mugSteps = {mugDiff, 2'b00};

   assign chIn[0] = inLeft;
   assign chIn[1] = inRight;

   for (genvar g = 0; g < 2; g++) begin : gChan
      drgc_sample_t       volOut;
      drgc_sample_t       dynOut;
      logic signed [39:0] mugWide;
      assign volOut = sat24(scaleDown(chIn[g], ~vol_r[g]));
      assign dynOut = sat24(scaleDown(volOut, gainAtt_r[15:8]));
      assign mugWide = scaleDown(dynOut, mugSteps) <<< mugShift;
      assign chOut[g] = sat24(mugWide);
   end

   // output buffer: a stalled receiver back-pressures through inReady
   assign pop = outValid_r & outReady;

   always_comb begin
      case ({accept, pop})
         2'b10:   count_nxt = count_r + 2'h1;
         2'b01:   count_nxt = count_r - 2'h1;
         default: count_nxt = count_r;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         count_r    <= 2'h0;
         ent0_r     <= 48'h000000000000;
         ent1_r     <= 48'h000000000000;
         outValid_r <= 1'b0;
         inReady_r  <= 1'b0;
      end else begin
         count_r    <= count_nxt;
         outValid_r <= count_nxt != 2'h0;
         inReady_r  <= count_nxt != 2'h2;
         if (pop) begin
            ent0_r <= (count_r == 2'h2) ? ent1_r : {chOut[0], chOut[1]};
         end else if (accept && count_r == 2'h0) begin
            ent0_r <= {chOut[0], chOut[1]};
         end
         if (accept && !pop && count_r == 2'h1) begin
            ent1_r <= {chOut[0], chOut[1]};
         end
      end
   end

   assign dat_o    = dat_r;
   assign ack_o    = ack_r;
   assign inReady  = inReady_r;
   assign outValid = outValid_r;
   assign outLeft  = ent0_r[47:24];
   assign outRight = ent0_r[23:0];

endmodule

// File: tb/drgc_properties.sv
// port-level timing and read-value checks of the gain block
`timescale 1ns/10ps
module drgc_properties(
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        inValid,
   input wire logic        inReady,
   input wire logic        outValid,
   input wire logic        outReady,
   input wire logic [23:0] outLeft,
   input wire logic [23:0] outRight
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire logic rdReq = cyc_i && stb_i && !we_i && !ack_o;
   a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not answered in one wait");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   a_hole_zero: assert property (rdReq && adr_i == 8'h3C |=> dat_o == 0)
      else $error("unmapped read not zero");
   a_cread_width: assert property (rdReq && adr_i == 8'h30 |=> dat_o[31:24] == 0)
      else $error("coefficient word wider than 24 bits");
   a_vol_width: assert property (rdReq && adr_i == 8'h04 |=> dat_o[31:16] == 0)
      else $error("volume read carries extra bits");
   a_out_hold: assert property (outValid && !outReady |=>
      outValid && $stable(outLeft) && $stable(outRight))
      else $error("output pair changed while stalled");
   a_take_out: assert property (inValid && inReady |=> outValid)
      else $error("taken pair not presented");
   a_rise_cause: assert property ($rose(outValid) |-> $past(inValid && inReady))
      else $error("output valid without a taken pair");
endmodule

// File: tb/drgc_sink.sv
// far-side sample sink: can stall, records every pair it accepts
`timescale 1ns/10ps
module drgc_sink(
   input wire logic        core_clk,
   input wire logic        stall,
   input wire logic        outValid,
   input wire logic [23:0] outLeft,
   input wire logic [23:0] outRight,
   output logic            outReady
);
   logic [47:0] q[$];
   assign outReady = !stall;
   always @(posedge core_clk) begin
      if (outValid && outReady) q.push_back({outLeft, outRight});
   end
endmodule

// File: tb/tb.sv
// register and stream tests of the gain block
`timescale 1ns/10ps
`include "drgc_defines.svh"
module tb;
   logic core_clk = 0, rst_b = 0, cyc_i = 0, stb_i = 0, we_i = 0;
   logic inValid = 0, stall = 0, ack_o, inReady, outValid, outReady;
   logic [7:0] adr_i = 0;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, dat_o, q;
   logic [23:0] inLeft = 0, inRight = 0, outLeft, outRight;
   logic [47:0] p;
   logic [7:0] ca[11] = '{8'h80, 8'h8C, 8'h91, 8'h97, 8'h9C, 8'hA3, 8'hA8,
                          8'h8A, 8'h8B, 8'hAE, 8'hAF};
   int failures = 0, total_checks = 0;
   drgc_top dut(.core_clk, .rst_b, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
      .sel_i, .dat_o, .ack_o, .inValid, .inLeft, .inRight, .inReady,
      .outValid, .outReady, .outLeft, .outRight);
   drgc_sink sink(.core_clk, .stall, .outValid, .outLeft, .outRight,
      .outReady);
   initial forever #50 core_clk = ~core_clk;
   task automatic chk(input string nm, input logic [47:0] s, e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do @(posedge core_clk); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      @(posedge core_clk);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, logic [31:0] e);
      bus(0, a, 0);
      chk(nm, q, e);
   endtask
   // the store drops address and data writes while busy, so always poll
   task automatic idle;
      do bus(0, `DRGC_OFF_STATUS, 0); while (q[0] !== 1'b0);
   endtask
   task automatic wcoef(input logic [7:0] a, input logic [23:0] v);
      bus(1, `DRGC_OFF_CADDR, a);
      bus(1, `DRGC_OFF_CWR_LO, v[7:0]);
      bus(1, `DRGC_OFF_CWR_MID, v[15:8]);
      bus(1, `DRGC_OFF_CWR_HI, v[23:16]);
      idle;
      bus(1, `DRGC_OFF_CADDR, a);
      idle;
   endtask
   task automatic send(input logic [23:0] l, r);
      inValid <= 1;
      inLeft <= l;
      inRight <= r;
      do @(posedge core_clk); while (inReady !== 1'b1);
      inValid <= 0;
      @(posedge core_clk);
   endtask
   task automatic pop(input string nm, input logic [47:0] e);
      chk(nm, sink.q.size() > 0 ? sink.q.pop_front() : 48'hX, e);
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #3000000;
      failures++;
      tally_and_finish;
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1;
      rd("vol", `DRGC_OFF_VOL, 32'h0000FFFF);
      rd("limth", `DRGC_OFF_LIMTH, 32'h000000FF);
      rd("ctrl", `DRGC_OFF_CTRL, 32'h0);
      rd("hole", 8'h3C, 32'h0);
      idle;
      foreach (ca[k]) begin
         bus(1, `DRGC_OFF_CADDR, ca[k]);
         idle;
         rd("coef", `DRGC_OFF_CREAD, k < 7 ? `DRGC_UNITY_Q22 : 24'h0);
      end
      bus(1, `DRGC_OFF_CADDR, 8'h84);
      idle;
      rd("c84", `DRGC_OFF_CREAD, 32'h0);
      idle;
      rd("c85", `DRGC_OFF_CREAD, 32'h400000);
      wcoef(8'hAE, 24'h123456);
      rd("widen", `DRGC_OFF_CREAD, 32'h123456);
      wcoef(8'h8A, 24'h100000);
      bus(0, `DRGC_OFF_STATUS, 0);
      chk("nlf", q[1], 1'b1);
      rd("nlfw", `DRGC_OFF_CREAD, 32'h100000);
      send(24'h123456, 24'hEDCBA9);
      repeat (6) @(posedge core_clk);
      pop("pass", 48'h123456EDCBA9);
      bus(1, `DRGC_OFF_VOL, 32'hFFEF);
      send(24'h123456, 24'h123456);
      repeat (6) @(posedge core_clk);
      p = sink.q.size() > 0 ? sink.q.pop_front() : 48'hX;
      chk("minus6", p[47:24] >= 24'h091A00 && p[47:24] <= 24'h091C00, 1);
      chk("right", p[23:0], 24'h123456);
      bus(1, `DRGC_OFF_VOL, 32'hFFFF);
      bus(1, `DRGC_OFF_MUGAIN, 32'h4);
      send(24'h7FFFFF, 24'h800000);
      send(24'h600000, 24'hA00000);
      repeat (6) @(posedge core_clk);
      pop("clamp", 48'h7FFFFF800000);
      pop("makeup", 48'h7FFFFF800000);
      bus(1, `DRGC_OFF_MUGAIN, 32'h0);
      stall <= 1;
      send(24'h000001, 24'h000002);
      send(24'h000003, 24'h000004);
      repeat (6) @(posedge core_clk);
      chk("held", sink.q.size(), 0);
      stall <= 0;
      repeat (6) @(posedge core_clk);
      pop("first", 48'h000001000002);
      pop("second", 48'h000003000004);
      // 0 dB peak against a 16-step threshold at 4:1 gives 12 steps
      bus(1, `DRGC_OFF_COMPTH, 32'hEF);
      bus(1, `DRGC_OFF_LIMTH, 32'hF7);
      bus(1, `DRGC_OFF_RATIO, 32'h104);
      bus(1, `DRGC_OFF_CTRL, 32'h1B);
      repeat (64) send(24'h800000, 24'h000000);
      bus(0, `DRGC_OFF_STATUS, 0);
      chk("comp", q[23:8], 16'h000C);
      tally_and_finish;
   end
endmodule
bind drgc_top drgc_properties props(.core_clk, .rst_b, .cyc_i, .stb_i,
   .we_i, .adr_i, .dat_o, .ack_o, .inValid, .inReady, .outValid, .outReady,
   .outLeft, .outRight);
